// file: logic/ttc_consts.vh
// Constants for the thermal throttle control block
`ifndef TTC_CONSTS_VH
`define TTC_CONSTS_VH

// Misc enable register field positions
`define TTC_MISC_DUTY_EN_BIT 3
`define TTC_MISC_FV_EN_BIT 13
// Thermal-2 control register fields
`define TTC_T2_SELECT_BIT 16
`define TTC_T2_TARGET_MSB 15
`define TTC_T2_TARGET_LSB 0
`define TTC_T2_RESET 17'h00000
// Feature identification bit positions
`define TTC_FEAT_DUTY_BIT 29
`define TTC_FEAT_FV_BIT 8
// Thermal status bit positions
`define TTC_STAT_LIVE_BIT 0
`define TTC_STAT_LOG_BIT 1
// Minimum engaged time in microseconds and clock in MHz
`define TTC_MIN_HOLD_US 1000
`define TTC_CLK_MHZ 50
`define TTC_MIN_HOLD_CYC (`TTC_MIN_HOLD_US * `TTC_CLK_MHZ)
// Duty modulation period and default on-slots (of 8)
`define TTC_DUTY_PERIOD 8
`define TTC_DUTY_ON_DEF 4

`endif

// file: logic/ttc_sync.v
// Two-flop synchroniser for the sensor trip inputs
`timescale 1ns/1ps

module ttc_sync #(
    parameter WIDTH = 2
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // First stage feeds only the second stage
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// file: logic/ttc_top.v
// Thermal throttle control: shutdown latch, throttle engage, duty gating, target request
`timescale 1ns/1ps
`include "ttc_consts.vh"

// Overview of the datapath
// Three comparator levels arrive from the sensor side: the catastrophic level,
// the throttle trip level and a lower hysteresis level. All three are brought
// into the core clock domain by one shared two-flop stage before anything reads
// them, so every consumer sees the same cycle of every trip.
//
// The catastrophic path is a single sticky flop. It has no enable, no clear and
// no readback, on purpose: nothing that software writes can delay or hide a
// shutdown. Only the block reset releases it.
//
// The throttle path is a small three-state engine. A trip moves it from idle to
// a hold state that lasts a fixed number of cycles, then to a wait state that
// only ends once both the trip and the hysteresis comparators read clear. The
// hold stops the throttle from chattering when the die sits at the trip point.
//
// While engaged, at most one of two actions is applied, chosen by the enable bits:
// duty gating drops the core clock enable for part of every modulation period,
// and frequency mode raises a request that carries the programmed target.
// Frequency mode wins when both would apply, so the two never stack.
//
// Limitations a user must know:
// - The configuration registers are plain write ports; the block cannot stop
//   software from rewriting enables or the target after firmware set them.
// - The duty ratio is fixed at build time; there is no run-time duty field.
// - The hold time is counted in core clocks, so a slower clock lengthens it
//   unless the parameter is scaled to match.

// How it works
// - Catastrophic trip halts core until reset
// - Catastrophic detection always on, invisible
// - Throttle trip precedes catastrophic trip
// - Duty mode gates clock internally only
// - Duty means clock-allowed time fraction
// - Misc bit 3 enables duty; resets clear
// - Feature bit 29 reports duty support
// - Feature bit 8 reports frequency support
// - Same trip drives frequency/voltage lowering
// - Legacy: select flag plus bit 3
// - Legacy: bit 3 without flag selects duty
// - Newer scheme: misc bit 13 enables frequency
// - Trip moves to thermal-2 target field
// - Hold engaged minimum time, hysteresis release
// - Live status bit while throttling
// - Sticky log bit, software or reset clears
module ttc_top #(
    parameter MIN_HOLD_CYC = `TTC_MIN_HOLD_CYC,
    parameter LEGACY_SCHEME = 0,
    parameter DUTY_PERIOD = `TTC_DUTY_PERIOD,
    parameter [3:0] DUTY_ON = `TTC_DUTY_ON_DEF
) (
    input wire I_REF_CLK,
    input wire I_RST_N,
    input wire I_CATASTROPHIC_TRIP,
    input wire I_THROTTLE_TRIP,
    input wire I_THROTTLE_TRIP_LOW,
    input wire [31:0] I_MISC_ENABLE_WDATA,
    input wire I_MISC_ENABLE_WE,
    input wire [16:0] I_THERMAL2_CONTROL_WDATA,
    input wire I_THERMAL2_CONTROL_WE,
    input wire I_STATUS_LOG_CLR,
    output wire [31:0] O_MISC_ENABLE,
    output wire [16:0] O_THERMAL2_CONTROL,
    output wire [31:0] O_FEATURE_EDX,
    output wire [31:0] O_FEATURE_ECX,
    output wire [1:0] O_THERMAL_STATUS,
    output wire O_CORE_HALT,
    output wire O_CORE_CLK_EN,
    output wire O_OP_POINT_REQ,
    output wire [15:0] O_OP_POINT_TARGET
);
    localparam ST_IDLE = 3'b001;
    localparam ST_HOLD = 3'b010;
    localparam ST_WAIT = 3'b100;
    localparam [31:0] HOLD_LAST = MIN_HOLD_CYC - 1;

    reg misc_duty_en_r;
    reg misc_fv_en_r;
    reg [16:0] t2_ctl_r;
    reg halt_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [31:0] hold_cnt_r;
    reg [31:0] hold_cnt_nxt;
    reg log_r;
    reg [3:0] slot_r;
    reg clk_en_r;
    reg req_r;
    reg [15:0] target_r;
    wire [2:0] trips_s;
    wire cat_s;
    wire trip_s;
    wire trip_low_s;
    wire engaged;
    wire [1:0] mode_w;
    wire fv_mode;
    wire duty_mode;

    // Trip comparators are asynchronous to the core clock
    ttc_sync #(.WIDTH(3)) u_sync (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .i_async({I_THROTTLE_TRIP_LOW, I_THROTTLE_TRIP, I_CATASTROPHIC_TRIP}),
        .o_sync(trips_s)
    );
    // Throttle comparator sits below shutdown, so it engages first on a rise
    assign cat_s = trips_s[0];
    assign trip_s = trips_s[1];
    assign trip_low_s = trips_s[2];

    // Mode decode, one function shared by gating and request paths
    function [1:0] mode_dec;
        input duty_en;
        input fv_en;
        input sel;
        input legacy;
        reg fv;
        begin
            if (legacy != 0) begin
                fv = duty_en & sel;
            end else begin
                fv = fv_en;
            end
            // Frequency mode wins, so duty never stacks on top
            mode_dec = {fv, duty_en & ~fv};
        end
    endfunction

    // One decode result feeds both action paths, so they can never disagree
    // about which mode is live in a given cycle
    assign mode_w = mode_dec(misc_duty_en_r, misc_fv_en_r, t2_ctl_r[`TTC_T2_SELECT_BIT],
        LEGACY_SCHEME[0]);
    assign fv_mode = mode_w[1];
    assign duty_mode = mode_w[0];

    // Configuration registers; enables clear at reset
    // Only the two enable bits are stored; other misc bits read back as zero.
    // A write takes effect at the edge that sees the strobe, and the new mode
    // applies to the action paths from the following cycle.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            misc_duty_en_r <= 1'b0;
            misc_fv_en_r <= 1'b0;
            t2_ctl_r <= `TTC_T2_RESET;
        end else begin
            if (I_MISC_ENABLE_WE) begin
                misc_duty_en_r <= I_MISC_ENABLE_WDATA[`TTC_MISC_DUTY_EN_BIT];
                misc_fv_en_r <= I_MISC_ENABLE_WDATA[`TTC_MISC_FV_EN_BIT];
            end
            if (I_THERMAL2_CONTROL_WE) begin
                t2_ctl_r <= I_THERMAL2_CONTROL_WDATA;
            end
        end
    end

    // Catastrophic latch has no enable and no status path; only reset clears it
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            halt_r <= 1'b0;
        end else if (cat_s) begin
            halt_r <= 1'b1;
        end
    end

    // Engage state: hold the minimum time, then wait for the low threshold
    // The hold counter only runs in the hold state and restarts on every new
    // engagement; a trip that returns during the wait state simply keeps the
    // engine in wait, it does not restart the minimum time.
    always @* begin
        state_nxt = state_r;
        hold_cnt_nxt = hold_cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (trip_s) begin
                    state_nxt = ST_HOLD;
                    hold_cnt_nxt = 32'h00000000;
                end
            end
            ST_HOLD: begin
                if (hold_cnt_r >= HOLD_LAST) begin
                    state_nxt = ST_WAIT;
                end else begin
                    hold_cnt_nxt = hold_cnt_r + 32'h00000001;
                end
            end
            ST_WAIT: begin
                // Hysteresis: release only once the lower comparator is clear too
                if (!trip_s && !trip_low_s) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                hold_cnt_nxt = 32'h00000000;
            end
        endcase
    end

    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            state_r <= ST_IDLE;
            hold_cnt_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
        end
    end

    assign engaged = (state_r != ST_IDLE);

    // Sticky log; a new trip wins over a same-cycle clear
    // Letting the trip win means a clear can never swallow an event that
    // arrives in the very cycle software acknowledges the previous one.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            log_r <= 1'b0;
        end else if (trip_s) begin
            log_r <= 1'b1;
        end else if (I_STATUS_LOG_CLR) begin
            log_r <= 1'b0;
        end
    end

    // Duty gating: clock allowed for DUTY_ON of each DUTY_PERIOD slots, internal only
    // The slot counter free-runs so the gating phase does not depend on when
    // the trip arrived; the cost is a partial first period after engagement.
    // The enable is a flop so the clock gate downstream sees a clean level.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            slot_r <= 4'h0;
            clk_en_r <= 1'b1;
        end else begin
            if (slot_r >= DUTY_PERIOD - 1) begin
                slot_r <= 4'h0;
            end else begin
                slot_r <= slot_r + 4'h1;
            end
            // Halted core keeps its clock off regardless of throttling
            if (halt_r || cat_s) begin
                clk_en_r <= 1'b0;
            end else if (engaged && duty_mode) begin
                clk_en_r <= (slot_r < DUTY_ON);
            end else begin
                clk_en_r <= 1'b1;
            end
        end
    end

    // Operating-point request, carrying the programmed target
    // The target is copied every cycle, so it is settled before the request
    // rises and follows any later write to the control register.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            req_r <= 1'b0;
            target_r <= 16'h0000;
        end else begin
            req_r <= engaged && fv_mode;
            target_r <= t2_ctl_r[`TTC_T2_TARGET_MSB:`TTC_T2_TARGET_LSB];
        end
    end

    // Readback and identification
    // Feature bits are constants: both throttle modes are always built in.
    assign O_MISC_ENABLE = ({31'h00000000, misc_duty_en_r} << `TTC_MISC_DUTY_EN_BIT)
        | ({31'h00000000, misc_fv_en_r} << `TTC_MISC_FV_EN_BIT);
    assign O_THERMAL2_CONTROL = t2_ctl_r;
    assign O_FEATURE_EDX = 32'h00000001 << `TTC_FEAT_DUTY_BIT;
    assign O_FEATURE_ECX = 32'h00000001 << `TTC_FEAT_FV_BIT;
    assign O_THERMAL_STATUS = {log_r, engaged};
    assign O_CORE_HALT = halt_r;
    assign O_CORE_CLK_EN = clk_en_r;
    assign O_OP_POINT_REQ = req_r;
    assign O_OP_POINT_TARGET = target_r;
endmodule

// file: verif/ttc_sensor_model.sv
// Sensor trip comparators facing the throttle block
`timescale 1ns/1ps
module ttc_sensor_model #(
    parameter LOW_T = 8'h50,
    parameter HIGH_T = 8'h5A,
    parameter CAT_T = 8'h78
) (
    input wire [7:0] i_temp,
    output wire o_cat_trip,
    output wire o_thr_trip,
    output wire o_thr_low
);
    // Throttle point sits below shutdown point, so throttling trips first on a gradual rise
    assign o_thr_trip = i_temp >= HIGH_T;
    assign o_cat_trip = i_temp >= CAT_T;
    assign o_thr_low = i_temp >= LOW_T;
endmodule

// file: verif/ttc_top_assertions.sv
// Concurrent checks on the thermal throttle control ports
`timescale 1ns/1ps
module ttc_assertions #(
    parameter MIN_HOLD_CYC = 20
) (
    input wire I_REF_CLK,
    input wire I_RST_N,
    input wire I_CATASTROPHIC_TRIP,
    input wire I_THROTTLE_TRIP,
    input wire I_STATUS_LOG_CLR,
    input wire [31:0] O_MISC_ENABLE,
    input wire [31:0] O_FEATURE_EDX,
    input wire [31:0] O_FEATURE_ECX,
    input wire [1:0] O_THERMAL_STATUS,
    input wire O_CORE_HALT,
    input wire O_CORE_CLK_EN,
    input wire O_OP_POINT_REQ
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    // Engaged cycles so far; a counter since the hold is too long to unroll
    logic [31:0] hold_r;
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) hold_r <= 32'h0;
        else hold_r <= O_THERMAL_STATUS[0] ? hold_r + 32'h1 : 32'h0;
    end
    halt_sticky_a: assert property (O_CORE_HALT |=> O_CORE_HALT)
        else $error("halt released without reset");
    halt_rise_a: assert property ($rose(I_CATASTROPHIC_TRIP) |-> ##3 O_CORE_HALT)
        else $error("halt late");
    feat_bits_a: assert property (O_FEATURE_EDX[29] && O_FEATURE_ECX[8])
        else $error("feature bits clear");
    status_live_a: assert property ($rose(I_THROTTLE_TRIP) |-> ##3 O_THERMAL_STATUS[0])
        else $error("live status late");
    log_sticky_a: assert property (O_THERMAL_STATUS[1] && !I_STATUS_LOG_CLR |=> O_THERMAL_STATUS[1])
        else $error("log lost");
    hold_min_a: assert property ($fell(O_THERMAL_STATUS[0]) |-> hold_r >= MIN_HOLD_CYC)
        else $error("hold too short");
    no_mode_a: assert property (O_MISC_ENABLE == 32'h0 && $past(O_MISC_ENABLE) == 32'h0
        |-> !O_OP_POINT_REQ && (O_CORE_CLK_EN || O_CORE_HALT)) else $error("acted while off");
    fv_wins_a: assert property (O_OP_POINT_REQ && !O_CORE_HALT |-> O_CORE_CLK_EN)
        else $error("gated in frequency mode");
endmodule
bind ttc_top ttc_assertions #(.MIN_HOLD_CYC(MIN_HOLD_CYC)) u_ttc_assertions (.*);

// file: verif/ttc_top_test.sv
// Directed scenarios for the thermal throttle control block
`timescale 1ns/1ps
module ttc_top_test;
    logic clk = 1'b0, rst_n = 1'b0, mwe = 1'b0, twe = 1'b0, lclr = 1'b0;
    logic [7:0] temp = 8'h20;
    logic [31:0] mdat = 32'h0;
    logic [16:0] tdat = 17'h0;
    wire [31:0] misc, fedx, fecx;
    wire [16:0] t2;
    wire [15:0] tgt;
    wire [1:0] st;
    wire halt, clk_en, req, cat, thr, thr_lo, lclk_en, lreq;
    wire [15:0] ltgt;
    int errors = 0, compares = 0, n, ln;
    initial forever #10 clk = ~clk;
    ttc_sensor_model u_ttc_sensor_model (.i_temp(temp), .o_cat_trip(cat), .o_thr_trip(thr),
        .o_thr_low(thr_lo));
    ttc_top #(.MIN_HOLD_CYC(20), .DUTY_ON(4'h3)) u_ttc_top (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .I_CATASTROPHIC_TRIP(cat), .I_THROTTLE_TRIP(thr), .I_THROTTLE_TRIP_LOW(thr_lo),
        .I_MISC_ENABLE_WDATA(mdat), .I_MISC_ENABLE_WE(mwe), .I_THERMAL2_CONTROL_WDATA(tdat),
        .I_THERMAL2_CONTROL_WE(twe), .I_STATUS_LOG_CLR(lclr), .O_MISC_ENABLE(misc),
        .O_THERMAL2_CONTROL(t2), .O_FEATURE_EDX(fedx), .O_FEATURE_ECX(fecx),
        .O_THERMAL_STATUS(st), .O_CORE_HALT(halt), .O_CORE_CLK_EN(clk_en),
        .O_OP_POINT_REQ(req), .O_OP_POINT_TARGET(tgt));
    // Same stimulus into the legacy enabling scheme
    ttc_top #(.MIN_HOLD_CYC(20), .LEGACY_SCHEME(1), .DUTY_ON(4'h3)) u_ttc_top_legacy (
        .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CATASTROPHIC_TRIP(cat), .I_THROTTLE_TRIP(thr),
        .I_THROTTLE_TRIP_LOW(thr_lo), .I_MISC_ENABLE_WDATA(mdat), .I_MISC_ENABLE_WE(mwe),
        .I_THERMAL2_CONTROL_WDATA(tdat), .I_THERMAL2_CONTROL_WE(twe), .I_STATUS_LOG_CLR(lclr),
        .O_MISC_ENABLE(), .O_THERMAL2_CONTROL(), .O_FEATURE_EDX(), .O_FEATURE_ECX(),
        .O_THERMAL_STATUS(), .O_CORE_HALT(), .O_CORE_CLK_EN(lclk_en),
        .O_OP_POINT_REQ(lreq), .O_OP_POINT_TARGET(ltgt));
    task automatic ck(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    // Sampling lands 1 ns after the edge so the edge's own updates are seen
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic rst();
        rst_n <= 1'b0;
        step(6);
        rst_n <= 1'b1;
        step(3);
    endtask
    task automatic wr(input logic [31:0] m, input logic [16:0] t);
        {mdat, tdat, mwe, twe} <= {m, t, 2'h3};
        step(1);
        {mwe, twe} <= 2'h0;
        step(1);
    endtask
    task automatic heat(input logic [7:0] t);
        temp <= t;
        step(1);
    endtask
    // Bounded wait on the live status; running out ends the run
    task automatic wait_st(input logic v);
        for (n = 0; st[0] !== v; n++) begin
            if (n == 200) begin
                errors++;
                test_done();
            end
            step(1);
        end
    endtask
    task automatic count_en();
        n = 0;
        ln = 0;
        repeat (8) begin
            step(1);
            n += (clk_en === 1'b1);
            ln += (lclk_en === 1'b1);
        end
    endtask
    task automatic t_duty();
        wr(32'h8, 17'h0);
        heat(8'h60);
        wait_st(1'b1);
        heat(8'h20);
        step(1);
        count_en();
        ck(n == 3 && req === 1'b0, "duty slots");
        ck(ln == 3 && lreq === 1'b0, "legacy duty slots");
        step(3);
        ck(st[0] === 1'b1, "hold ended early");
        wait_st(1'b0);
        step(2);
        ck(st === 2'h2 && clk_en === 1'b1, "release");
        lclr <= 1'b1;
        step(1);
        lclr <= 1'b0;
        step(1);
        ck(st === 2'h0, "log clear");
    endtask
    task automatic t_fv(input logic [31:0] m);
        wr(m, 17'h1A5C3);
        ck(misc === m && t2 === 17'h1A5C3, "readback");
        heat(8'h60);
        wait_st(1'b1);
        step(2);
        ck(req === 1'b1 && tgt === 16'hA5C3, "target request");
        ck(lreq === 1'b1 && ltgt === 16'hA5C3, "legacy target request");
        count_en();
        ck(n == 8 && ln == 8, "gated in frequency mode");
        heat(8'h20);
        wait_st(1'b0);
        step(2);
        ck(req === 1'b0, "request held");
    endtask
    task automatic t_none();
        wr(32'h0, 17'h10000);
        heat(8'h60);
        wait_st(1'b1);
        step(2);
        count_en();
        ck(n == 8 && req === 1'b0 && st[0] === 1'b1, "acted while off");
        ck(ln == 8 && lreq === 1'b0, "legacy select alone acted");
        heat(8'h20);
        wait_st(1'b0);
    endtask
    task automatic t_cat();
        heat(8'h80);
        step(4);
        ck(halt === 1'b1 && clk_en === 1'b0, "no halt");
        heat(8'h20);
        step(30);
        ck(halt === 1'b1, "halt released");
        rst();
        ck(halt === 1'b0 && misc === 32'h0, "reset state");
    endtask
    task automatic test_done();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rst();
        ck(misc === 32'h0 && t2 === 17'h0 && st === 2'h0, "reset values");
        ck(fedx[29] === 1'b1 && fecx[8] === 1'b1, "feature bits");
        t_duty();
        t_fv(32'h2008);
        t_none();
        t_cat();
        test_done();
    end
endmodule
